// [bench/pitc_pci_engine.sv]
// Purpose: pci bus engine model that feeds initiator events
// Assumes: events change just after a rising edge
// Notes:   hit gives the index of the event that saw an abort, 0 if none
module pitc_pci_engine
  import pitc_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      retry_abort,
  input  wire logic      trdy_abort,
  output pitc_init_evt_t init_evt
);
  timeunit 1ns;
  timeprecision 100ps;
  initial init_evt = '0;
  // one event cycle, aborts looked at mid-cycle
  task automatic step(input pitc_init_evt_t e, output logic ra, output logic ta);
    init_evt <= e;
    @(negedge clk_sys);
    ra = retry_abort;
    ta = trdy_abort;
    @(posedge clk_sys);
  endtask
  task automatic retries(input int n, output int hit);
    logic ra, ta;
    hit = 0;
    step(5'h10, ra, ta);
    for (int i = 1; i <= n; i++)
    begin
      step(5'h04, ra, ta);
      if (ra === 1'b1 && hit == 0) hit = i;
    end
    step(5'h00, ra, ta);
  endtask
  task automatic waits(input pitc_init_evt_t first, input int n, output int hit);
    logic ra, ta;
    hit = 0;
    step(first, ra, ta);
    for (int i = 1; i <= n; i++)
    begin
      step(5'h02, ra, ta);
      if (ta === 1'b1 && hit == 0) hit = i;
    end
    step(5'h00, ra, ta);
  endtask
endmodule // pitc_pci_engine

// [bench/test_pitc_regs.sv]
// Purpose: self-checking bench for the timeout and config register bank
// Assumes: zero-wait ahb slave, engine model on the event port
// Notes:   all bus calls start right after a rising edge
module test_pitc_regs;
  import pitc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk_sys = 1'b0;
  logic              rst_n, hsel, hwrite, hready, hreadyout, irq;
  logic              add_in_card_mode, retry_abort, trdy_abort;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  pitc_eeprom_load_t eeprom_load;
  pitc_init_evt_t    init_evt;
  int                error_cnt = 0;
  int                n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  pitc_regs #(.CNT_W(8)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .add_in_card_mode(add_in_card_mode),
    .eeprom_load(eeprom_load), .init_evt(init_evt), .retry_abort(retry_abort),
    .trdy_abort(trdy_abort), .irq(irq));
  pitc_pci_engine u_eng (.clk_sys(clk_sys), .retry_abort(retry_abort),
    .trdy_abort(trdy_abort), .init_evt(init_evt));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic load(input logic [7:0] ml, input logic [7:0] mg, input logic [7:0] pin);
    eeprom_load <= {1'b1, ml, mg, pin};
    @(posedge clk_sys);
    eeprom_load <= '0;
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    test_done;
  end
  initial
  begin
    int hit;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    add_in_card_mode = 1'b0;
    eeprom_load = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rc(PITC_OFF_CAP_PTR, 32'h000000dc);
    rc(PITC_OFF_CFG2, 32'h0a020100);
    rc(PITC_OFF_TO_LIMITS, 32'h00008080);
    rc(PITC_OFF_TO_STATUS, 32'h0);
    rc(PITC_OFF_TO_MASK, 32'h0);
    $display("test reset values done");
    wr(PITC_OFF_CAP_PTR, 32'hffffffff);
    wr(PITC_OFF_CFG2, 32'hffffffa5);
    rc(PITC_OFF_CAP_PTR, 32'h000000dc);
    rc(PITC_OFF_CFG2, 32'h0a0201a5);
    rc(16'hd050, 32'h0);
    for (int p = 0; p <= 4; p++)
    begin
      load(8'h33, 8'h44, 8'(p));
      rc(PITC_OFF_CFG2, {16'h3344, 8'(p), 8'ha5});
    end
    load(8'h33, 8'h44, 8'h07);
    rc(PITC_OFF_CFG2, 32'h334404a5);
    $display("test config fields done");
    wr(PITC_OFF_TO_LIMITS, 32'h00000203);
    wr(PITC_OFF_TO_MASK, 32'h3);
    u_eng.retries(3, hit);
    chk(32'(hit), 32'h3);
    irq_is(1'b1);
    wr(PITC_OFF_TO_STATUS, 32'h0);
    rc(PITC_OFF_TO_STATUS, 32'h1);
    wr(PITC_OFF_TO_STATUS, 32'h1);
    rc(PITC_OFF_TO_STATUS, 32'h0);
    irq_is(1'b0);
    repeat (2)
    begin
      u_eng.retries(2, hit);
      chk(32'(hit), 32'h0);
    end
    u_eng.waits(5'h08, 4, hit);
    chk(32'(hit), 32'h4);
    rc(PITC_OFF_TO_STATUS, 32'h2);
    irq_is(1'b1);
    wr(PITC_OFF_TO_MASK, 32'h1);
    irq_is(1'b0);
    wr(PITC_OFF_TO_STATUS, 32'h2);
    rc(PITC_OFF_TO_STATUS, 32'h0);
    repeat (2)
    begin
      u_eng.waits(5'h08, 3, hit);
      chk(32'(hit), 32'h0);
    end
    u_eng.waits(5'h01, 3, hit);
    chk(32'(hit), 32'h0);
    wr(PITC_OFF_TO_MASK, 32'h2);
    u_eng.retries(3, hit);
    irq_is(1'b0);
    wr(PITC_OFF_TO_STATUS, 32'h1);
    $display("test timeouts done");
    wr(PITC_OFF_TO_LIMITS, 32'h0);
    u_eng.retries(5, hit);
    chk(32'(hit), 32'h0);
    u_eng.waits(5'h08, 5, hit);
    chk(32'(hit), 32'h0);
    rc(PITC_OFF_TO_STATUS, 32'h0);
    $display("test zero limits done");
    add_in_card_mode <= 1'b1;
    wr(PITC_OFF_CFG2, 32'h0000005a);
    wr(PITC_OFF_TO_LIMITS, 32'h00000101);
    rc(PITC_OFF_CFG2, 32'h0);
    rc(PITC_OFF_CAP_PTR, 32'h0);
    add_in_card_mode <= 1'b0;
    rc(PITC_OFF_CFG2, 32'h334404a5);
    rc(PITC_OFF_TO_LIMITS, 32'h0);
    $display("test card mode done");
    test_done;
  end
endmodule // test_pitc_regs

// [hw/pitc_pkg.sv]
// Purpose: shared constants and types for the initiator timeout and config register bank
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses within the block window
package pitc_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] PITC_OFF_CAP_PTR   = 16'hd034;
  localparam logic [15:0] PITC_OFF_CFG2      = 16'hd03c;
  localparam logic [15:0] PITC_OFF_TO_LIMITS = 16'hd040;
  localparam logic [15:0] PITC_OFF_TO_STATUS = 16'hd080;
  localparam logic [15:0] PITC_OFF_TO_MASK   = 16'hd084;

  // ---------------------------------------------------------------------------
  // fixed and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PITC_CAP_LIST_OFFSET = 8'hdc;
  localparam logic [7:0] PITC_RST_MAX_LATENCY = 8'h0a;
  localparam logic [7:0] PITC_RST_MIN_GRANT   = 8'h02;
  localparam logic [7:0] PITC_RST_IRQ_PIN     = 8'h01;
  localparam logic [7:0] PITC_RST_IRQ_LINE    = 8'h00;
  localparam logic [7:0] PITC_RST_RETRY_LIM   = 8'h80;
  localparam logic [7:0] PITC_RST_TRDY_LIM    = 8'h80;
  localparam logic [7:0] PITC_IRQ_PIN_MAX     = 8'h04;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int PITC_BIT_RETRY_TO = 0;
  localparam int PITC_BIT_TRDY_TO  = 1;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] max_latency_field;
    logic [7:0] min_grant_field;
    logic [7:0] irq_pin_select;
    logic [7:0] irq_line_scratch;
  } pitc_cfg2_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] max_latency_field;
    logic [7:0] min_grant_field;
    logic [7:0] irq_pin_select;
  } pitc_eeprom_load_t;

  // initiator-side events from the pci bus engine
  typedef struct packed {
    logic txn_start;
    logic phase_start;
    logic retry_term;
    logic trdy_wait;
    logic trdy_seen;
  } pitc_init_evt_t;

endpackage : pitc_pkg

// [hw/pitc_regs.sv]
// Purpose: initiator timeout counters plus config-mirror registers on AHB-Lite
// Assumes: one clock; pci engine events are synchronous single-cycle pulses or levels
// Notes:   zero-wait-state slave, always OKAY
//
// What this block does
// R1: capability pointer reads fixed 0xdc, read-only
// R2: add-in-card mode hides all these registers
// R3: max latency resets to 0x0a
// R4: min grant resets to 0x02
// R5: interrupt pin resets to 1, codes 0-4
// R6: latency, grant, pin read-only, eeprom loadable
// R7: interrupt line plain read-write, reset zero
// R8: retries beyond limit end transaction with error
// R9: zero retry limit disables retry timeout
// R10: target ready wait bounded by limit clocks
// R11: zero wait limit disables that timeout
// R12: target ready timeout sets sticky bit 1
// R13: retry timeout sets sticky bit 0
// R14: bit 1 mask enables target-ready interrupt
// R15: bit 0 mask enables retry interrupt
// R16: counters restart per transaction and phase
//
// Design decision made here: the AHB-Lite register port.
module pitc_regs
  import pitc_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              add_in_card_mode,
  input  wire pitc_eeprom_load_t eeprom_load,
  input  wire pitc_init_evt_t    init_evt,
  output logic                   retry_abort,
  output logic                   trdy_abort,
  output logic                   irq
);

  // ---------------------------------------------------------------------------
  // bus address phase capture
  // ---------------------------------------------------------------------------
  logic        ap_valid;
  logic        ap_write;
  logic [15:0] ap_addr;
  logic        wr_en;
  logic        rd_en;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 16'h0000;
    end
    else if (hready)
    begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[15:0];
    end
  end

  // writes land in the data phase; reads are decoded in the address phase
  assign wr_en     = ap_valid && ap_write && !add_in_card_mode; // R2
  assign rd_en     = hsel && htrans[1] && !hwrite && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------------------
  // configuration mirror
  // ---------------------------------------------------------------------------
  logic [7:0] max_latency_field;
  logic [7:0] min_grant_field;
  logic [7:0] irq_pin_select;
  logic [7:0] irq_line_scratch;
  pitc_cfg2_t cfg2;

  // one driver for the whole carrier; the fields live in separate flops
  assign cfg2 = {max_latency_field, min_grant_field, irq_pin_select, irq_line_scratch};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      max_latency_field <= PITC_RST_MAX_LATENCY; // R3
      min_grant_field   <= PITC_RST_MIN_GRANT; // R4
      irq_pin_select    <= PITC_RST_IRQ_PIN; // R5
    end
    else if (eeprom_load.valid)
    begin
      max_latency_field <= eeprom_load.max_latency_field; // R6
      min_grant_field   <= eeprom_load.min_grant_field; // R6
      // reserved pin codes are refused, keeping the previous selection
      if (eeprom_load.irq_pin_select <= PITC_IRQ_PIN_MAX)
      begin
        irq_pin_select <= eeprom_load.irq_pin_select; // R5
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_line_scratch <= PITC_RST_IRQ_LINE;
    end
    else if (wr_en && ap_addr == PITC_OFF_CFG2)
    begin
      irq_line_scratch <= hwdata[7:0]; // R7
    end
  end

  // ---------------------------------------------------------------------------
  // timeout limits
  // ---------------------------------------------------------------------------
  logic [7:0] retry_limit;
  logic [7:0] target_ready_wait_limit;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retry_limit             <= PITC_RST_RETRY_LIM; // R8
      target_ready_wait_limit <= PITC_RST_TRDY_LIM; // R10
    end
    else if (wr_en && ap_addr == PITC_OFF_TO_LIMITS)
    begin
      retry_limit             <= hwdata[15:8];
      target_ready_wait_limit <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // retry counter
  // ---------------------------------------------------------------------------
  logic [CNT_W:0] retry_cnt;
  logic           retry_to_evt;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retry_cnt <= '0;
    end
    else if (init_evt.txn_start)
    begin
      retry_cnt <= '0; // R16
    end
    else if (init_evt.retry_term && !retry_cnt[CNT_W])
    begin
      retry_cnt <= retry_cnt + 1'b1;
    end
  end

  // the retry that pushes the count past the limit raises the timeout
  assign retry_to_evt = init_evt.retry_term && !init_evt.txn_start
                        && (retry_limit != 8'h00) // R9
                        && (retry_cnt[CNT_W-1:0] == retry_limit); // R8
  assign retry_abort  = retry_to_evt; // R8

  // ---------------------------------------------------------------------------
  // target ready wait counter
  // ---------------------------------------------------------------------------
  logic [CNT_W:0] trdy_cnt;
  logic           trdy_to_evt;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trdy_cnt <= '0;
    end
    else if (init_evt.phase_start || init_evt.trdy_seen)
    begin
      trdy_cnt <= '0; // R16
    end
    else if (init_evt.trdy_wait && !trdy_cnt[CNT_W])
    begin
      trdy_cnt <= trdy_cnt + 1'b1;
    end
  end

  assign trdy_to_evt = init_evt.trdy_wait && !init_evt.phase_start && !init_evt.trdy_seen
                       && (target_ready_wait_limit != 8'h00) // R11
                       && (trdy_cnt[CNT_W-1:0] == target_ready_wait_limit); // R10
  assign trdy_abort  = trdy_to_evt; // R10

  // ---------------------------------------------------------------------------
  // sticky status and mask
  // ---------------------------------------------------------------------------
  logic [1:0] err_flags;
  logic [1:0] irq_en;
  logic [1:0] w1c;

  assign w1c = (wr_en && ap_addr == PITC_OFF_TO_STATUS) ? hwdata[1:0] : 2'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_flags <= 2'h0;
    end
    else
    begin
      err_flags[PITC_BIT_RETRY_TO] <= retry_to_evt
                                      || (err_flags[PITC_BIT_RETRY_TO]
                                          && !w1c[PITC_BIT_RETRY_TO]); // R13
      err_flags[PITC_BIT_TRDY_TO]  <= trdy_to_evt
                                      || (err_flags[PITC_BIT_TRDY_TO]
                                          && !w1c[PITC_BIT_TRDY_TO]); // R12
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en <= 2'h0; // R14 R15
    end
    else if (wr_en && ap_addr == PITC_OFF_TO_MASK)
    begin
      irq_en <= hwdata[1:0];
    end
  end

  assign irq = |(err_flags & irq_en); // R14 R15

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (!add_in_card_mode) // R2
    begin
      unique case (haddr[15:0])
        PITC_OFF_CAP_PTR:   next_rdata = {24'h000000, PITC_CAP_LIST_OFFSET}; // R1
        PITC_OFF_CFG2:      next_rdata = cfg2;
        PITC_OFF_TO_LIMITS: next_rdata = {16'h0000, retry_limit, target_ready_wait_limit};
        PITC_OFF_TO_STATUS: next_rdata = {30'h0, err_flags};
        PITC_OFF_TO_MASK:   next_rdata = {30'h0, irq_en};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      hrdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_cap_read;
    rd_en && !add_in_card_mode && haddr[15:0] == PITC_OFF_CAP_PTR;
  endsequence

  a_cap_ptr_fixed: assert property (s_cap_read |=> hrdata == 32'h0000_00dc) // R1
    else $error("capability pointer read wrong");

  a_card_mode_hidden: assert property (rd_en && add_in_card_mode |=> hrdata == 32'h0) // R2
    else $error("register visible in add-in-card mode");

  a_cfg_ro_fields: assert property (!eeprom_load.valid |=> $stable(cfg2[31:8])) // R6
    else $error("read-only config field changed");

  a_line_write: assert property (wr_en && ap_addr == PITC_OFF_CFG2
                                 |=> irq_line_scratch == $past(hwdata[7:0])) // R7
    else $error("interrupt line not stored");

  a_retry_off: assert property (retry_limit == 8'h00 |-> !retry_abort) // R9
    else $error("retry timeout while disabled");

  a_trdy_off: assert property (target_ready_wait_limit == 8'h00 |-> !trdy_abort) // R11
    else $error("target ready timeout while disabled");

  a_retry_flag_set: assert property (retry_abort |=> err_flags[0]) // R13
    else $error("retry flag not set");

  sequence s_trdy_flag_held;
    err_flags[PITC_BIT_TRDY_TO]
      ##1 (err_flags[PITC_BIT_TRDY_TO] || $past(w1c[PITC_BIT_TRDY_TO]));
  endsequence

  a_trdy_flag_set: assert property (trdy_abort |=> s_trdy_flag_held) // R12
    else $error("target ready flag not sticky");

  a_irq_gate: assert property (irq == ((err_flags[1] && irq_en[1])
                                       || (err_flags[0] && irq_en[0]))) // R14
    else $error("interrupt not gated by mask");

  a_retry_restart: assert property (init_evt.txn_start |=> retry_cnt == '0) // R16
    else $error("retry count not restarted");

  // ---------------------------------------------------------------------------
  // timeout, pin code and card-mode checks
  // ---------------------------------------------------------------------------
  // limit-specific runs: two retries allowed, the third one aborts
  sequence s_retry_run_two;
    init_evt.txn_start ##1 (init_evt.retry_term && !init_evt.txn_start) [*2];
  endsequence

  sequence s_retry_run_three;
    init_evt.txn_start ##1 (init_evt.retry_term && !init_evt.txn_start) [*3];
  endsequence

  sequence s_trdy_run_four;
    init_evt.phase_start
      ##1 (init_evt.trdy_wait && !init_evt.phase_start && !init_evt.trdy_seen) [*4];
  endsequence

  sequence s_retry_flag_held;
    err_flags[PITC_BIT_RETRY_TO]
      ##1 (err_flags[PITC_BIT_RETRY_TO] || $past(w1c[PITC_BIT_RETRY_TO]));
  endsequence

  a_retry_not_early: assert property ((retry_limit == 8'h02) ##0 s_retry_run_two // R8
                                      |-> !retry_abort)
    else $error("retry timeout before limit exceeded");

  a_retry_on_excess: assert property ((retry_limit == 8'h02) ##0 s_retry_run_three // R8
                                      |-> retry_abort)
    else $error("retry timeout missed");

  a_trdy_on_excess: assert property ((target_ready_wait_limit == 8'h03) // R10
                                     ##0 s_trdy_run_four |-> trdy_abort)
    else $error("target ready timeout missed");

  a_retry_flag_keep: assert property (retry_abort |=> s_retry_flag_held) // R13
    else $error("retry flag not sticky");

  a_retry_flag_clear: assert property (w1c[PITC_BIT_RETRY_TO] && !retry_to_evt // R13
                                       |=> !err_flags[PITC_BIT_RETRY_TO])
    else $error("retry flag not cleared");

  a_trdy_flag_clear: assert property (w1c[PITC_BIT_TRDY_TO] && !trdy_to_evt // R12
                                      |=> !err_flags[PITC_BIT_TRDY_TO])
    else $error("target ready flag not cleared");

  a_trdy_restart: assert property (init_evt.phase_start || init_evt.trdy_seen // R16
                                   |=> trdy_cnt == '0)
    else $error("target ready count not restarted");

  a_pin_code_legal: assert property (irq_pin_select <= PITC_IRQ_PIN_MAX) // R5
    else $error("reserved interrupt pin code stored");

  a_card_write_block: assert property (ap_valid && ap_write && add_in_card_mode // R2
                                       |=> $stable(irq_line_scratch) && $stable(irq_en)
                                           && $stable(retry_limit)
                                           && $stable(target_ready_wait_limit))
    else $error("register written in add-in-card mode");

  a_irq_retry_path: assert property (err_flags[0] && irq_en[0] |-> irq) // R15
    else $error("unmasked retry flag gives no interrupt");

  a_limits_write: assert property (wr_en && ap_addr == PITC_OFF_TO_LIMITS // R8 R10
                                   |=> {retry_limit, target_ready_wait_limit}
                                       == $past(hwdata[15:0]))
    else $error("timeout limits not stored");

endmodule // pitc_regs
